// ---- fch_pkg.sv ----
// shared constants and carrier types for the floppy command flag handler
// assumes a 250 MHz system clock and a 32-bit avalon-mm register slave
package fch_pkg;

  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int SETTLE_MS = 15;
  localparam int SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
  localparam int TEST_STEP_CYC = 250;
  localparam logic [31:0] STEP_OVERHEAD = 32'h00000003; // check and step states plus the wait cycle at a zero count
  localparam logic [7:0] STEP_MS [4] = '{8'h06, 8'h0C, 8'h14, 8'h1E};
  localparam logic [2:0] ROT_LIMIT = 3'h6;
  localparam logic [7:0] INNER_TRACK = 8'h2B;

  // register byte offsets
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_TRACK = 5'h04;
  localparam logic [4:0] OFS_SECTOR = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0C;
  localparam logic [4:0] OFS_EVT = 5'h10;
  localparam logic [4:0] OFS_EVT_CLR = 5'h14;
  localparam logic [4:0] OFS_EVT_EN = 5'h18;

  // command byte field positions
  localparam int B_UPD = 4;
  localparam int B_HLD = 3;
  localparam int B_VFY = 2;
  localparam int B_MULTI = 4;
  localparam int B_SIDE = 3;
  localparam int B_DELAY = 2;
  localparam int B_CMP = 1;
  localparam int B_MARK = 0;

  // event bits and data marks
  localparam int EV_DONE = 0;
  localparam int EV_SEEK = 1;
  localparam int EV_RNF = 2;
  localparam logic [7:0] MARK_DELETED = 8'hF8;
  localparam logic [7:0] MARK_NORMAL = 8'hFB;

  // reset values
  localparam logic [7:0] TRACK_RST = 8'h00;
  localparam logic [7:0] SECTOR_RST = 8'h01;
  localparam logic [2:0] EVT_EN_RST = 3'h0;

  typedef enum logic [3:0] {
    FCH_IDLE = 4'h0,
    FCH_T1_CHK = 4'h1,
    FCH_T1_STEP = 4'h2,
    FCH_T1_WAIT = 4'h3,
    FCH_VERIFY = 4'h4,
    FCH_SETTLE = 4'h5,
    FCH_HL_WAIT = 4'h6,
    FCH_SEARCH = 4'h7,
    FCH_XFER = 4'h8,
    FCH_DONE = 4'h9
  } fch_state_t;

  // sector id as delivered by the read channel
  typedef struct packed {
    logic valid;
    logic [7:0] track;
    logic side;
    logic [7:0] sector;
  } fch_id_t;

  // drive control outputs
  typedef struct packed {
    logic head_load;
    logic step;
    logic step_in;
    logic inner_track;
  } fch_drive_t;

endpackage

// ---- fch_sync.sv ----
// three-stage input synchroniser; output moves once stages two and three agree
// assumes an asynchronous input and the common system clock
`timescale 1ns/1ns
module fch_sync import fch_pkg::*; #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } fch_sync_t;

  fch_sync_t r, next_r;

  // stage one feeds stage two only
  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.q = r.s3;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.q;

endmodule // fch_sync

// ---- fch_timer.sv ----
// loadable down counter; done is high while the count sits at zero
// assumes the load value already includes any clock scaling
`timescale 1ns/1ns
module fch_timer import fch_pkg::*; #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } fch_timer_t;

  fch_timer_t r, next_r;

  // load wins over counting
  always_comb begin
    next_r = r;
    if (load) begin
      next_r.cnt = value;
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = (r.cnt == '0);

endmodule // fch_timer

// ---- fch_top.sv ----
// command flag handler of a floppy controller with an avalon-mm register slave
// assumes drive pins are asynchronous and the read channel runs on clock
//
// What this block does
// - with head load set, a positioning command loads the head as it starts.
// - with head load clear, the head loads only when verify begins, never without verify.
// - verify compares track to sector ids and flags a seek error after 6 turns.
// - step spacing comes from the two rate bits, the clock rate and the test input.
// - with update set, each inward step adds one to track and outward subtracts one.
// - with delay set, head settle timing is sampled 15 ms after head load rises.
// - with delay clear, head settle timing is sampled at once after head load.
// - in a read or write command, once head load and settle timing are both high the inner track output updates.
// - multi-sector adds one to sector after each transfer and seeks the next one.
// - a missing sector by the sixth turn ends the run with record missing error.
// - with compare set the id side must equal the side select flag.
// - a sector write uses mark F8 when deleted mark select is 1, else FB.
// - completion raises the request, a status read or command write drops it.
`timescale 1ns/1ns
module fch_top import fch_pkg::*; #(
  parameter int MS_CYC = CYC_PER_MS,
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int TEST_CYCLES = TEST_STEP_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic head_settle_timing_input,
  input wire logic index_pulse_n,
  input wire logic track0_n,
  input wire logic test_n,
  input wire fch_id_t id_in,
  input wire logic xfer_done,
  output fch_drive_t drive,
  output logic xfer_start,
  output logic xfer_is_write,
  output logic [7:0] data_mark,
  output logic completion_interrupt_request,
  output logic irq
);

  typedef struct packed {
    fch_state_t st;
    logic [7:0] cmd;
    logic [7:0] track;
    logic [7:0] sector;
    logic [7:0] data;
    logic busy;
    logic seek_err;
    logic record_missing_error;
    logic req;
    logic [2:0] evt;
    logic [2:0] evt_en;
    logic ack;
    logic [31:0] rdata;
    fch_drive_t drv;
    logic idx_prev;
    logic [2:0] turns;
    logic xstart;
    logic xwr;
    logic [7:0] mark;
  } fch_regs_t;

  fch_regs_t r, next_r;
  logic head_settle_timing_input_s;
  logic index_s;
  logic track0_s;
  logic test_s;
  logic t_load;
  logic [31:0] t_val;
  logic t_done;

  // drive pins are asynchronous; active low ones idle high
  fch_sync #(.RST_VAL(1'b0)) u_sync_head_settle_timing_input (
    .clock(clock), .reset_n(reset_n),
    .din(head_settle_timing_input), .dout(head_settle_timing_input_s));
  fch_sync #(.RST_VAL(1'b1)) u_sync_idx (
    .clock(clock), .reset_n(reset_n), .din(index_pulse_n), .dout(index_s));
  fch_sync #(.RST_VAL(1'b1)) u_sync_tr0 (
    .clock(clock), .reset_n(reset_n), .din(track0_n), .dout(track0_s));
  fch_sync #(.RST_VAL(1'b1)) u_sync_test (
    .clock(clock), .reset_n(reset_n), .din(test_n), .dout(test_s));

  // one timer serves step spacing and head settle
  fch_timer #(.W(32)) u_timer (
    .clock(clock), .reset_n(reset_n),
    .load(t_load), .value(t_val), .done(t_done));

  // step spacing in cycles; test low forces the short spacing
  function automatic logic [31:0] step_cycles(input logic [1:0] rate,
                                              input logic test_hi);
    logic [31:0] ms;
    ms = {24'h000000, STEP_MS[rate]};
    if (!test_hi) begin
      step_cycles = 32'(TEST_CYCLES);
    end else begin
      step_cycles = 32'(ms * 32'(MS_CYC));
    end
  endfunction

  // command decode from fixed bit positions
  logic is_t1;
  logic is_t2;
  logic is_t4;
  logic is_restore;
  logic is_seek;
  logic is_write;
  logic id_hit;
  logic idx_edge;
  logic turns_out;
  logic bus_req;
  logic bus_go;

  always_comb begin
    is_t1 = ~r.cmd[7];
    is_t2 = (r.cmd[7:6] == 2'h2);
    is_t4 = (avs_writedata[7:4] == 4'hD);
    is_restore = (r.cmd[7:4] == 4'h0);
    is_seek = (r.cmd[7:4] == 4'h1);
    is_write = (r.cmd[7:5] == 3'h5) || (r.cmd[7:4] == 4'hF);
    idx_edge = r.idx_prev & ~index_s;
    turns_out = idx_edge && (r.turns == ROT_LIMIT - 3'h1);
    bus_req = avs_read | avs_write;
    bus_go = bus_req & r.ack;
    // side check only when compare is set
    id_hit = id_in.valid && (id_in.track == r.track) && (id_in.sector == r.sector)
      && (!r.cmd[B_CMP] || (id_in.side == r.cmd[B_SIDE]));
  end

  // bus slave, command sequencing and event flags
  always_comb begin
    next_r = r;
    t_load = 1'b0;
    t_val = 32'h00000000;
    next_r.drv.step = 1'b0;
    next_r.xstart = 1'b0;
    next_r.idx_prev = index_s;
    next_r.ack = bus_req & ~r.ack;
    if (idx_edge) begin
      next_r.turns = r.turns + 3'h1;
    end

    // read data is latched one cycle ahead of the answer
    if (bus_req && !r.ack) begin
      case (avs_address)
        OFS_CMD: next_r.rdata = {26'h0, ~track0_s, r.drv.inner_track,
          r.drv.head_load, r.record_missing_error, r.seek_err, r.busy};
        OFS_TRACK: next_r.rdata = {24'h0, r.track};
        OFS_SECTOR: next_r.rdata = {24'h0, r.sector};
        OFS_DATA: next_r.rdata = {24'h0, r.data};
        OFS_EVT: next_r.rdata = {29'h0, r.evt};
        OFS_EVT_EN: next_r.rdata = {29'h0, r.evt_en};
        default: next_r.rdata = 32'h00000000;
      endcase
    end

    // status read drops the completion request
    if (bus_go && avs_read && avs_address == OFS_CMD) begin
      next_r.req = 1'b0;
    end

    if (bus_go && avs_write) begin
      case (avs_address)
        OFS_CMD: begin
          next_r.req = 1'b0;
          if (!r.busy) begin
            // a new command is accepted only while idle
            next_r.cmd = avs_writedata[7:0];
            next_r.busy = ~is_t4;
            next_r.seek_err = 1'b0;
            next_r.record_missing_error = 1'b0;
            next_r.st = is_t4 ? FCH_DONE : FCH_T1_CHK;
            next_r.xwr = 1'b0;
            if (!avs_writedata[7]) begin
              next_r.drv.head_load = avs_writedata[B_HLD];
            end else if (!is_t4) begin
              next_r.st = FCH_SETTLE;
              next_r.drv.head_load = 1'b1;
              t_load = 1'b1;
              // settle delay only when the delay flag is set
              t_val = avs_writedata[B_DELAY] ? 32'(SETTLE_CYCLES) : 32'h00000000;
            end
          end else if (is_t4) begin
            next_r.st = FCH_DONE;
          end
        end
        OFS_TRACK: if (!r.busy) next_r.track = avs_writedata[7:0];
        OFS_SECTOR: if (!r.busy) next_r.sector = avs_writedata[7:0];
        OFS_DATA: next_r.data = avs_writedata[7:0];
        OFS_EVT_CLR: next_r.evt = r.evt & ~avs_writedata[2:0];
        OFS_EVT_EN: next_r.evt_en = avs_writedata[2:0];
        default: next_r.evt_en = r.evt_en;
      endcase
    end

    case (r.st)
      FCH_IDLE: begin
        // hold; a command write above starts the sequence
      end
      FCH_T1_CHK: begin
        // decide whether another step is needed
        if (is_restore && !track0_s) begin
          next_r.track = 8'h00;
          next_r.st = FCH_VERIFY;
        end else if (is_seek && r.track == r.data) begin
          next_r.st = FCH_VERIFY;
        end else begin
          if (is_seek) begin
            next_r.drv.step_in = (r.data > r.track);
          end else if (is_restore) begin
            next_r.drv.step_in = 1'b0;
          end else if (r.cmd[6]) begin
            next_r.drv.step_in = ~r.cmd[5];
          end
          next_r.st = FCH_T1_STEP;
        end
        if (next_r.st == FCH_VERIFY) begin
          next_r.turns = 3'h0;
          next_r.drv.head_load = r.drv.head_load | r.cmd[B_VFY];
          if (!r.cmd[B_VFY]) begin
            next_r.st = FCH_DONE;
          end
        end
      end
      FCH_T1_STEP: begin
        next_r.drv.step = 1'b1;
        t_load = 1'b1;
        // check and step states are part of the spacing; spacings below them are out of reach
        t_val = step_cycles(r.cmd[1:0], test_s) - STEP_OVERHEAD;
        // seek and restore always track; single steps only with update
        if ((is_t1 && r.cmd[B_UPD]) || r.cmd[7:5] == 3'h0) begin
          next_r.track = r.drv.step_in ? r.track + 8'h01 : r.track - 8'h01;
        end
        next_r.st = FCH_T1_WAIT;
      end
      // seek and restore loop back; single steps go on to verify
      FCH_T1_WAIT: if (t_done) begin
        next_r.st = (r.cmd[7:5] == 3'h0) ? FCH_T1_CHK : FCH_VERIFY;
        if (r.cmd[7:5] != 3'h0) begin
          next_r.turns = 3'h0;
          next_r.drv.head_load = r.drv.head_load | r.cmd[B_VFY];
          if (!r.cmd[B_VFY]) begin
            next_r.st = FCH_DONE;
          end
        end
      end
      // any valid id on the expected track ends the search
      FCH_VERIFY: begin
        if (id_in.valid && id_in.track == r.track) begin
          next_r.st = FCH_DONE;
        end else if (turns_out) begin
          next_r.seek_err = 1'b1;
          next_r.st = FCH_DONE;
        end
      end
      // a zero load finishes on the next cycle, so no delay
      FCH_SETTLE: if (t_done) begin
        next_r.st = FCH_HL_WAIT;
      end
      // mark chosen here so it stands before the first transfer
      FCH_HL_WAIT: if (r.drv.head_load && head_settle_timing_input_s) begin
        next_r.drv.inner_track = (r.track > INNER_TRACK);
        next_r.turns = 3'h0;
        next_r.xwr = is_write;
        next_r.mark = r.cmd[B_MARK] ? MARK_DELETED : MARK_NORMAL;
        next_r.st = is_t2 ? FCH_SEARCH : FCH_XFER;
        next_r.xstart = ~is_t2;
      end
      // turn count restarts per sector, so each one gets six turns
      FCH_SEARCH: begin
        if (id_hit) begin
          next_r.xstart = 1'b1;
          next_r.st = FCH_XFER;
        end else if (turns_out) begin
          next_r.record_missing_error = 1'b1;
          next_r.st = FCH_DONE;
        end
      end
      // transfer end decides between the next sector and completion
      FCH_XFER: if (xfer_done) begin
        if (is_t2 && r.cmd[B_MULTI]) begin
          next_r.sector = r.sector + 8'h01;
          next_r.turns = 3'h0;
          next_r.st = FCH_SEARCH;
        end else begin
          next_r.st = FCH_DONE;
        end
      end
      FCH_DONE: begin
        // completion beats a same-cycle status read
        next_r.busy = 1'b0;
        next_r.req = 1'b1;
        next_r.drv.head_load = 1'b0;
        next_r.st = FCH_IDLE;
      end
      default: next_r.st = FCH_IDLE;
    endcase

    // an abort outranks whatever the sequence chose this cycle
    if (bus_go && avs_write && avs_address == OFS_CMD && r.busy && is_t4) begin
      next_r.st = FCH_DONE;
    end

    // sticky events set after any clear, so a set is never lost
    if (r.st == FCH_DONE) begin
      next_r.evt[EV_DONE] = 1'b1;
    end
    if (next_r.seek_err && !r.seek_err) begin
      next_r.evt[EV_SEEK] = 1'b1;
    end
    if (next_r.record_missing_error && !r.record_missing_error) begin
      next_r.evt[EV_RNF] = 1'b1;
    end
  end

  // one register holds all state; reset loads constants only
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '{st: FCH_IDLE, track: TRACK_RST, sector: SECTOR_RST,
        evt_en: EVT_EN_RST, idx_prev: 1'b1, mark: MARK_NORMAL, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // outputs
  assign avs_waitrequest = bus_req & ~r.ack;
  assign avs_readdata = r.rdata;
  assign drive = r.drv;
  assign xfer_start = r.xstart;
  assign xfer_is_write = r.xwr;
  assign data_mark = r.mark;
  assign completion_interrupt_request = r.req;
  assign irq = |(r.evt & r.evt_en);

endmodule // fch_top

// ---- fch_properties.sv ----
// concurrent checks on the ports of the command flag handler
// assumes the bench shortens the settle count and changes test_n only between commands
`timescale 1ns/1ns
module fch_checker import fch_pkg::*; #(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire fch_drive_t drive,
  input wire logic xfer_start,
  input wire logic [7:0] data_mark,
  input wire logic completion_interrupt_request
);
  logic [7:0] cmd_q;
  logic hl_off;
  int cnt;
  wire take = avs_write && !avs_waitrequest && avs_address == OFS_CMD;
  wire [7:0] cmd = avs_writedata[7:0];
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // last command kept; an abort leaves the flags of the aborted one
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cmd_q <= 8'h00;
      hl_off <= 1'b0;
      cnt <= 0;
    end else begin
      if (take && cmd[7:4] != 4'hD) cmd_q <= cmd;
      if (take) hl_off <= !cmd[7] && cmd[3:2] == 2'h0;
      if (take) cnt <= 0;
      else if (cnt < SETTLE_CYCLES) cnt <= cnt + 1; // saturates, no wrap
    end
  end
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_step_gap: assert property (drive.step |=> !drive.step [*3])
    else $error("step pulses too close");
  a_hl_first: assert property (take && !cmd[7] && cmd[B_HLD] |-> ##[1:2] drive.head_load)
    else $error("head not loaded at command start");
  a_hl_never: assert property (hl_off |-> !drive.head_load)
    else $error("head loaded without head load or verify");
  a_mark_pick: assert property (xfer_start && cmd_q[7:5] == 3'h5 |->
    data_mark == (cmd_q[B_MARK] ? MARK_DELETED : MARK_NORMAL))
    else $error("wrong data mark");
  a_settle_wait: assert property (xfer_start && cmd_q[7] && cmd_q[B_DELAY] |->
    cnt >= SETTLE_CYCLES)
    else $error("transfer before settle delay");
  a_xfer_loaded: assert property (xfer_start |-> drive.head_load)
    else $error("transfer with head unloaded");
  a_req_drop: assert property ($fell(completion_interrupt_request) |->
    $past(avs_address == OFS_CMD && (avs_read || avs_write) && !avs_waitrequest))
    else $error("request dropped without status read or command");
endmodule // fch_checker

bind fch_top fch_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) fch_checker_inst (.clock, .reset_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .drive,
  .xfer_start, .data_mark, .completion_interrupt_request);

// ---- fch_drive_model.sv ----
// behavioural floppy drive: head position, index, sector ids, transfers
// assumes one turn of 64 clocks with sectors 1 to 4 on it
`timescale 1ns/1ns
module fch_drive_model import fch_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire fch_drive_t drive,
  input wire logic xfer_start,
  input wire logic side_id,
  output fch_id_t id_in,
  output logic xfer_done,
  output logic index_pulse_n,
  output logic track0_n
);
  logic [7:0] cyl;
  logic [5:0] ph;
  logic [3:0] xc;
  wire v = ph[3:0] == 4'h8;
  // head moves only on a step pulse; a transfer lasts eight clocks
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cyl <= 8'h00;
      ph <= 6'h00;
      xc <= 4'h0;
    end else begin
      ph <= ph + 6'h01;
      if (drive.step) cyl <= drive.step_in ? cyl + 8'h01 : cyl - 8'h01;
      if (xfer_start) xc <= 4'h8;
      else if (xc != 4'h0) xc <= xc - 4'h1;
    end
  end
  // track and side are inverted between ids so stale values never match
  assign id_in = '{valid: v, track: v ? cyl : ~cyl, side: side_id ^ !v,
    sector: {6'h00, ph[5:4]} + 8'h01};
  assign xfer_done = xc == 4'h1;
  assign index_pulse_n = ph >= 6'h04;
  assign track0_n = cyl != 8'h00;
endmodule // fch_drive_model

// ---- floppy_command_flag_handler_tb_top.sv ----
// self-checking bench for the command flag handler
// assumes the drive model and the bound checker beside fch_top
`timescale 1ns/1ns
module floppy_command_flag_handler_tb_top import fch_pkg::*;;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic hst = 1'b1;
  logic test_n = 1'b0;
  logic side_id = 1'b0;
  logic index_pulse_n, track0_n, xfer_done, xfer_start, xfer_is_write;
  logic completion_interrupt_request, irq, hl_seen, xw, xinner;
  logic [7:0] data_mark, xmark;
  logic [31:0] q;
  fch_id_t id_in;
  fch_drive_t drive;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int nxs, nstep, gap, tstep, txs, t0;

  always #2 clock = ~clock;

  fch_top #(.MS_CYC(10), .SETTLE_CYCLES(20), .TEST_CYCLES(4)) fch_top_inst (.clock, .reset_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .head_settle_timing_input(hst), .index_pulse_n, .track0_n, .test_n, .id_in, .xfer_done,
    .drive, .xfer_start, .xfer_is_write, .data_mark, .completion_interrupt_request, .irq);
  fch_drive_model fch_drive_model_inst (.clock, .reset_n, .drive, .xfer_start, .side_id,
    .id_in, .xfer_done, .index_pulse_n, .track0_n);

  // tallies of drive activity; also cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (drive.step) begin
      nstep <= nstep + 1;
      gap <= cyc - tstep;
      tstep <= cyc;
    end
    if (xfer_start) begin
      nxs <= nxs + 1;
      txs <= cyc;
      xmark <= data_mark;
      xw <= xfer_is_write;
      xinner <= drive.inner_track;
    end
    if (drive.head_load) hl_seen <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // one avalon access; holds until waitrequest is sampled low
  // waitrequest and read data are looked at in the low half of the cycle,
  // so the values are those that the next rising edge sees
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    logic wr;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(negedge clock);
      wr = avs_waitrequest;
      q = avs_readdata;
      @(posedge clock);
    end while (wr !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rg(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", q, e);
  endtask

  task automatic go(input logic [7:0] c);
    nxs = 0;
    nstep = 0;
    hl_seen = 1'b0;
    bus(1'b1, OFS_CMD, {24'h0, c});
    t0 = cyc;
  endtask

  // wait for completion, then read status, which drops the request
  task automatic fin();
    repeat (3000) if (completion_interrupt_request !== 1'b1) @(posedge clock);
    chk("request", completion_interrupt_request, 1);
    bus(1'b0, OFS_CMD, 32'h0);
    @(posedge clock);
    chk("request", completion_interrupt_request, 0);
  endtask

  task automatic run(input logic [7:0] c);
    go(c);
    fin();
  endtask

  task automatic t_regs();
    rg(OFS_TRACK, 32'h0);
    rg(OFS_SECTOR, 32'h1);
    rg(OFS_EVT_EN, 32'h0);
    rg(5'h1C, 32'h0);
    bus(1'b1, OFS_TRACK, 32'h5A);
    rg(OFS_TRACK, 32'h5A);
    bus(1'b1, OFS_TRACK, 32'h0);
  endtask

  // step in, step in without update, step out; head never loads
  task automatic t_step();
    run(8'h50);
    rg(OFS_TRACK, 32'h1);
    chk("head", hl_seen, 0);
    run(8'h40);
    rg(OFS_TRACK, 32'h1);
    chk("steps", nstep, 1);
    run(8'h70);
    rg(OFS_TRACK, 32'h0);
  endtask

  // head sits one track off the register, so the first verify must fail; the second, after a track write, passes
  task automatic t_seek();
    bus(1'b1, OFS_DATA, 32'h3);
    run(8'h1C);
    chk("head", hl_seen, 1);
    chk("seek error", q[EV_SEEK], 1);
    bus(1'b1, OFS_TRACK, 32'h4);
    bus(1'b1, OFS_DATA, 32'h6);
    test_n <= 1'b1;
    run(8'h15);
    chk("seek error", q[EV_SEEK], 0);
    chk("head", hl_seen, 1);
    chk("gap", gap, 120);
    test_n <= 1'b0;
  endtask

  task automatic t_sect();
    bus(1'b1, OFS_SECTOR, 32'h1);
    run(8'h90);
    chk("xfers", nxs, 4);
    chk("missing", q[2], 1);
    rg(OFS_SECTOR, 32'h5);
    bus(1'b1, OFS_SECTOR, 32'h2);
    run(8'h8A);
    chk("xfers", nxs, 0);
    run(8'h88);
    chk("xfers", nxs, 1);
    chk("write", xw, 0);
    chk("inner", xinner, 0);
    rg(OFS_SECTOR, 32'h2);
    for (int i = 0; i < 2; i++) begin
      run(8'hA0 | 8'(i));
      chk("mark", xmark, i ? MARK_DELETED : MARK_NORMAL);
      chk("write", xw, 1);
    end
  endtask

  // settle input held low stalls the transfer; delay flag adds the wait
  task automatic t_settle();
    hst <= 1'b0;
    bus(1'b1, OFS_TRACK, 32'h2C);
    go(8'hE0);
    repeat (60) @(posedge clock);
    chk("xfers", nxs, 0);
    hst <= 1'b1;
    fin();
    chk("inner", xinner, 1);
    run(8'hE4);
    chk("late", txs - t0 >= 20, 1);
    run(8'hE0);
    chk("early", txs - t0 < 20, 1);
    bus(1'b1, OFS_TRACK, 32'h6);
  endtask

  task automatic t_irq();
    bus(1'b1, OFS_EVT_CLR, 32'h7);
    bus(1'b1, OFS_EVT_EN, 32'h1);
    rg(OFS_EVT_EN, 32'h1);
    chk("irq", irq, 0);
    run(8'hD0);
    chk("irq", irq, 1);
    rg(OFS_EVT, 32'h1);
    bus(1'b1, OFS_EVT_EN, 32'h0);
    rg(OFS_EVT, 32'h1);
    chk("irq", irq, 0);
    bus(1'b1, OFS_EVT_EN, 32'h1);
    bus(1'b1, OFS_EVT_CLR, 32'h1);
    rg(OFS_EVT, 32'h0);
    chk("irq", irq, 0);
  endtask

  // abort a multi-sector run during its first transfer
  task automatic t_abort();
    bus(1'b1, OFS_SECTOR, 32'h1);
    go(8'h90);
    while (nxs == 0) @(posedge clock);
    run(8'hD0);
    chk("missing", q[2], 0);
    chk("xfers", nxs, 0);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_regs();
    t_step();
    t_seek();
    t_sect();
    t_settle();
    t_irq();
    t_abort();
    stop_test();
  end
endmodule // floppy_command_flag_handler_tb_top
